/* rtl/ccad_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module ccad_decode import ccad_pkg::*; #(
  parameter bit SERIAL_AT_10 = 1'b0, // relocate serial to 10-1f
  parameter bit BANK_FREE = 1'b0     // second rom-shadow map, bank line free
) (
  input wire logic i_clk,                       // 40 mhz clock
  input wire logic i_rst,                       // sync reset, high
  input wire logic [IO_ADDR_W-1:0] i_io_addr,   // port address
  input wire logic [MEM_ADDR_W-1:0] i_mem_addr, // memory address
  output logic o_serial_timer_irq_select,       // serial chip select, high
  output logic o_printer_latch_strobe,          // printer latch clock, high
  output logic o_memcfg_latch_strobe,           // config latch clock, high
  output logic o_any_port_n,                    // onboard port, low
  output logic o_rom_select_n,                  // rom socket, low
  output logic o_dram_bank_line,                // dram upper/lower 32k
  output logic o_onboard_ram_select_n,          // onboard ram, low
  output logic o_memory_expand_n                // expand bank, low
);
  localparam int IO_N = 2**IO_IDX_W;   // io entries
  localparam int MEM_N = 2**MEM_IDX_W; // memory entries

  // build io contents; recomputed consistently when serial moves
  function automatic logic [IO_N*ENTRY_W-1:0] io_rom();
    logic [IO_N*ENTRY_W-1:0] v;
    v = '0;
    for (int k = 0; k < IO_N; k++) begin
      v[k*ENTRY_W +: ENTRY_W] = IO_CODE_IDLE;
    end
    if (SERIAL_AT_10) begin
      v[IO_IDX_SERIAL_ALT*ENTRY_W +: ENTRY_W] = IO_CODE_SERIAL;
    end else begin
      v[IO_IDX_SERIAL*ENTRY_W +: ENTRY_W] = IO_CODE_SERIAL;
    end
    v[IO_IDX_PRINTER*ENTRY_W +: ENTRY_W] = IO_CODE_PRINTER;
    v[IO_IDX_MEMCFG*ENTRY_W +: ENTRY_W] = IO_CODE_MEMCFG;
    return v;
  endfunction : io_rom

  // build memory contents; upper table half holds the odd 2k blocks
  function automatic logic [MEM_N*ENTRY_W-1:0] mem_rom();
    logic [MEM_N*ENTRY_W-1:0] v;
    v = '0;
    for (int k = 0; k < MEM_N; k++) begin
      // entry k: bits 3:0 are a15-a12, so bit 3 tracks a15
      v[k*ENTRY_W +: ENTRY_W] = k[IO_IDX_W-1] ? MEM_CODE_HIGH : MEM_CODE_LOW;
      if (BANK_FREE) begin
        v[k*ENTRY_W +: ENTRY_W] = MEM_CODE_LOW;
      end
    end
    v[MEM_IDX_ROM*ENTRY_W +: ENTRY_W] = MEM_CODE_ROM;
    return v;
  endfunction : mem_rom

  // index wires
  wire logic [IO_IDX_W-1:0] io_idx = i_io_addr[IO_IDX_LSB +: IO_IDX_W];
  wire logic [MEM_IDX_W-1:0] mem_idx = {i_mem_addr[MEM_A11], i_mem_addr[MEM_A15:MEM_A12]};
  wire logic [ENTRY_W-1:0] io_entry;
  wire logic [ENTRY_W-1:0] mem_entry;

  // io table
  ccad_table #(.IDX_W(IO_IDX_W), .CONTENTS(io_rom())) u_io (
    .i_idx(io_idx),
    .o_entry(io_entry)
  );

  // memory table
  ccad_table #(.IDX_W(MEM_IDX_W), .CONTENTS(mem_rom())) u_mem (
    .i_idx(mem_idx),
    .o_entry(mem_entry)
  );

  // registered outputs cost one cycle of latency; reset shows all idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_serial_timer_irq_select <= 1'b0;
      o_printer_latch_strobe <= 1'b0;
      o_memcfg_latch_strobe <= 1'b0;
      o_any_port_n <= 1'b1;
      o_rom_select_n <= 1'b1;
      o_dram_bank_line <= 1'b0;
      o_onboard_ram_select_n <= 1'b1;
      o_memory_expand_n <= 1'b1;
    end else begin
      o_serial_timer_irq_select <= io_entry[IO_BIT_SERIAL];
      o_printer_latch_strobe <= io_entry[IO_BIT_PRINTER];
      o_memcfg_latch_strobe <= io_entry[IO_BIT_MEMCFG];
      o_any_port_n <= io_entry[IO_BIT_ANY_N];
      o_rom_select_n <= mem_entry[MEM_BIT_ROM_N];
      o_dram_bank_line <= mem_entry[MEM_BIT_BANK];
      o_onboard_ram_select_n <= mem_entry[MEM_BIT_RAM_N];
      o_memory_expand_n <= mem_entry[MEM_BIT_EXP_N];
    end
  end

  // serial select one cycle after a b0-bf port address
  a_serial_select: assert property (@(posedge i_clk) disable iff (i_rst)
    !SERIAL_AT_10 && i_io_addr[7:4] == 4'hb |=> o_serial_timer_irq_select && !o_any_port_n)
    else $error("serial select missing");
  a_printer_strobe: assert property (@(posedge i_clk) disable iff (i_rst)
    i_io_addr == 8'hd0 |=> o_printer_latch_strobe && !o_serial_timer_irq_select)
    else $error("printer strobe missing");
  a_any_port: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_serial_timer_irq_select || o_printer_latch_strobe || o_memcfg_latch_strobe) |-> !o_any_port_n)
    else $error("onboard flag not low");
  a_idle_port: assert property (@(posedge i_clk) disable iff (i_rst)
    i_io_addr[7:4] == 4'h0 |=> o_any_port_n && !o_memcfg_latch_strobe)
    else $error("idle port decoded");
  a_rom_block: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mem_addr[15:11] == 5'h00 |=> !o_rom_select_n && $past(i_mem_addr[15:11]) == 5'h00)
    else $error("rom select missing");
  a_rom_only: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mem_addr[15:11] != 5'h00 |=> o_rom_select_n && !o_onboard_ram_select_n)
    else $error("ram select wrong");
  a_bank_track: assert property (@(posedge i_clk) disable iff (i_rst)
    !BANK_FREE && i_mem_addr[15:11] != 5'h00 |=> o_dram_bank_line == $past(i_mem_addr[15]))
    else $error("bank line not tracking");
  a_expand_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> o_memory_expand_n)
    else $error("expand asserted");
endmodule : ccad_decode
`default_nettype wire

/* rtl/ccad_pkg.sv */
package ccad_pkg;
  // widths of the two decode tables
  localparam int IO_ADDR_W = 8;   // port address width
  localparam int IO_IDX_W = 4;    // io table index bits
  localparam int IO_IDX_LSB = 4;  // sixteen ports per entry
  localparam int MEM_ADDR_W = 16; // processor address width
  localparam int MEM_IDX_W = 5;   // 32 blocks of 2K
  localparam int ENTRY_W = 4;     // data bits per entry
  // address bit positions used for the memory table index
  localparam int MEM_A11 = 11;
  localparam int MEM_A12 = 12;
  localparam int MEM_A15 = 15;
  // entry bit positions
  localparam int IO_BIT_SERIAL = 0;
  localparam int IO_BIT_PRINTER = 1;
  localparam int IO_BIT_MEMCFG = 2;
  localparam int IO_BIT_ANY_N = 3;
  localparam int MEM_BIT_ROM_N = 0;
  localparam int MEM_BIT_BANK = 1;
  localparam int MEM_BIT_RAM_N = 2;
  localparam int MEM_BIT_EXP_N = 3;
  // factory io entries, one per 16-port group
  localparam logic [IO_IDX_W-1:0] IO_IDX_SERIAL = 4'hb; // ports b0-bf
  localparam logic [IO_IDX_W-1:0] IO_IDX_PRINTER = 4'hd; // group holding d0
  localparam logic [IO_IDX_W-1:0] IO_IDX_MEMCFG = 4'he; // chosen latch group
  localparam logic [IO_IDX_W-1:0] IO_IDX_SERIAL_ALT = 4'h1; // ports 10-1f
  localparam logic [ENTRY_W-1:0] IO_CODE_SERIAL = 4'h1; // select, onboard
  localparam logic [ENTRY_W-1:0] IO_CODE_PRINTER = 4'h2;
  localparam logic [ENTRY_W-1:0] IO_CODE_MEMCFG = 4'h4;
  localparam logic [ENTRY_W-1:0] IO_CODE_IDLE = 4'h8; // off-board port
  // factory memory entries
  localparam logic [ENTRY_W-1:0] MEM_CODE_ROM = 4'hc;  // rom at 0000-07ff
  localparam logic [ENTRY_W-1:0] MEM_CODE_LOW = 4'h9;  // ram, lower bank
  localparam logic [ENTRY_W-1:0] MEM_CODE_HIGH = 4'hb; // ram, upper bank
  localparam logic [MEM_IDX_W-1:0] MEM_IDX_ROM = 5'h00;
endpackage : ccad_pkg

/* rtl/ccad_table.sv */
`timescale 1ns/100ps
`default_nettype none
// one lookup table entry set, contents loaded as a constant vector
module ccad_table import ccad_pkg::*; #(
  parameter int IDX_W = 4, // index width
  parameter logic [(2**IDX_W)*ENTRY_W-1:0] CONTENTS = '0 // packed entries
) (
  input wire logic [IDX_W-1:0] i_idx,     // table index
  output logic [ENTRY_W-1:0] o_entry      // selected entry
);
  // plain indexed read, settles combinationally
  assign o_entry = CONTENTS[i_idx*ENTRY_W +: ENTRY_W];
endmodule : ccad_table
`default_nettype wire

/* tb/ccad_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
// processor address bus: launches each queued address just after the edge
module ccad_bus_model import ccad_pkg::*; (
  input wire logic i_clk, // bus clock
  input wire logic [IO_ADDR_W-1:0] i_io_next, // next port address
  input wire logic [MEM_ADDR_W-1:0] i_mem_next, // next memory address
  output logic [IO_ADDR_W-1:0] o_io_addr, // port address bus
  output logic [MEM_ADDR_W-1:0] o_mem_addr // memory address bus
);
  // defined bus at time zero
  initial begin
    o_io_addr = 8'h00;
    o_mem_addr = 16'h0000;
  end
  // fixed 1 ns launch delay keeps the edge sample free of races
  always @(posedge i_clk) begin
    o_io_addr <= #1 i_io_next;
    o_mem_addr <= #1 i_mem_next;
  end
endmodule : ccad_bus_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb import ccad_pkg::*;;
  logic i_clk = 1'b0; // 40 mhz
  logic i_rst = 1'b1; // sync reset
  logic [7:0] io_next = 8'h00, io_addr; // port address
  logic [15:0] mem_next = 16'h0000, mem_addr; // memory address
  logic [3:0] io_q, mem_q, io_a, mem_a; // factory and relocated outputs
  int err_total = 0, n_checks = 0, cyc = 0;
  // rows: port, memory address, factory io/mem codes, relocated io/mem codes
  logic [39:0] rows [9] = '{40'hb3_8800_1b89, 40'hbf_07ff_1c8c, 40'hc0_0800_8989,
    40'hd0_f800_2b29, 40'hdf_7fff_2929, 40'he0_8000_4b49, 40'h10_1000_8919,
    40'h1f_0000_8c1c, 40'haf_ffff_8b89};
  always #12.5 i_clk = ~i_clk;
  ccad_bus_model i_ccad_bus_model (.i_clk(i_clk), .i_io_next(io_next), .i_mem_next(mem_next),
    .o_io_addr(io_addr), .o_mem_addr(mem_addr));
  ccad_decode i_ccad_decode (.i_clk(i_clk), .i_rst(i_rst), .i_io_addr(io_addr), .i_mem_addr(mem_addr),
    .o_serial_timer_irq_select(io_q[0]), .o_printer_latch_strobe(io_q[1]), .o_memcfg_latch_strobe(io_q[2]),
    .o_any_port_n(io_q[3]), .o_rom_select_n(mem_q[0]), .o_dram_bank_line(mem_q[1]),
    .o_onboard_ram_select_n(mem_q[2]), .o_memory_expand_n(mem_q[3]));
  // second map: serial moved to 10-1f, bank line freed
  ccad_decode #(.SERIAL_AT_10(1'b1), .BANK_FREE(1'b1)) i_ccad_decode_alt (.i_clk(i_clk), .i_rst(i_rst),
    .i_io_addr(io_addr), .i_mem_addr(mem_addr), .o_serial_timer_irq_select(io_a[0]),
    .o_printer_latch_strobe(io_a[1]), .o_memcfg_latch_strobe(io_a[2]), .o_any_port_n(io_a[3]),
    .o_rom_select_n(mem_a[0]), .o_dram_bank_line(mem_a[1]), .o_onboard_ram_select_n(mem_a[2]),
    .o_memory_expand_n(mem_a[3]));
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // hang guard, far above the roughly 60 cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    io_next = 8'hb0;
    repeat (4) @(posedge i_clk);
    #2;
    chk("io in reset", io_q, 4'h8);
    chk("mem in reset", mem_q, 4'hd);
    i_rst = 1'b0;
    // table rows, both maps
    foreach (rows[r]) begin
      io_next = rows[r][39:32];
      mem_next = rows[r][31:16];
      repeat (2) @(posedge i_clk);
      #2;
      chk("io code", io_q, rows[r][15:12]);
      chk("mem code", mem_q, rows[r][11:8]);
      chk("io relocated", io_a, rows[r][7:4]);
      chk("mem bank free", mem_a, rows[r][3:0]);
    end
    $display("test rows done");
    // back to back sweep of all 32 blocks, one cycle latency each
    for (int i = 0; i < 34; i++) begin
      @(posedge i_clk);
      #2;
      if (i >= 2) chk("mem sweep", mem_q, (i == 2) ? 4'hc : (((i - 2) % 16) >= 8 ? 4'hb : 4'h9));
      mem_next = {i[3:0], i[4], 11'h000};
    end
    $display("test sweep done");
    // reset again in mid-run: outputs go idle, decode resumes after one edge
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #2;
    chk("io mid reset", io_q, 4'h8);
    chk("mem mid reset", mem_q, 4'hd);
    i_rst = 1'b0;
    io_next = 8'hd0;
    mem_next = 16'h8800;
    repeat (2) @(posedge i_clk);
    #2;
    chk("io after reset", io_q, 4'h2);
    chk("mem after reset", mem_q, 4'hb);
    $display("test reset done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
